// ---- rtl/dsi_pkg.sv ----
/*
 * dsi_pkg: shared constants and types for the diagnostic status indicator.
 * Assumes a single 100 MHz ref_clk; no software-visible registers.
 */
package dsi_pkg;

    // severity levels, gray coded along normal->warning->serious->critical
    typedef enum logic [1:0] {
        DSI_NORMAL   = 2'h0,
        DSI_WARNING  = 2'h1,
        DSI_SERIOUS  = 2'h3,
        DSI_CRITICAL = 2'h2
    } dsi_level_type;

    localparam int DSI_NUM_PARAM = 4;   // monitored environmental parameters
    localparam int DSI_VAL_W     = 12;  // width of one measured value

    // blink half period; slow so a pulled-up input samples it cleanly
    localparam int  DSI_CLK_HZ       = 100_000_000;
    localparam int  DSI_BLINK_MS     = 250;
    localparam int  DSI_BLINK_CYCLES = DSI_CLK_HZ / 1000 * DSI_BLINK_MS;
    localparam int  DSI_DIV_W        = 25;

    // released value of the open-drain enables (high = released); only s2_oe_n resets to it
    localparam logic DSI_OE_RELEASE = 1'b1;

    // led colour codes
    typedef enum logic [1:0] {
        DSI_LED_OFF    = 2'h0,
        DSI_LED_GREEN  = 2'h1,
        DSI_LED_ORANGE = 2'h2,
        DSI_LED_RED    = 2'h3
    } dsi_led_type;

    // one environmental measurement with its two limits
    typedef struct packed {
        logic [DSI_VAL_W-1:0] value;
        logic [DSI_VAL_W-1:0] harm_limit;   // preset harmful level
        logic [DSI_VAL_W-1:0] user_limit;   // user programmed level
        logic                 user_en;
    } dsi_env_type;

    // status wire group: output and active-low output enable per wire
    typedef struct packed {
        logic s1_out;
        logic s1_oe_n;
        logic s2_out;
        logic s2_oe_n;
    } dsi_wire_type;

endpackage

// ---- rtl/dsi_blink.sv ----
/*
 * dsi_blink: divider giving a one-cycle tick every blink half period and a
 * square-wave phase. Assumes synchronous active-low reset on ref_clk.
 */
`timescale 1ns/1ps
module dsi_blink
    import dsi_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    output logic      tick,
    output logic      phase
);

    logic [DSI_DIV_W-1:0] cnt_reg;
    logic [DSI_DIV_W-1:0] cnt_next;
    logic                 phase_reg;
    logic                 phase_next;

    ////////////////////////////////////////////////////////////////////////
    // free-running divider, phase flips on each tick
    always_comb begin
        tick       = (cnt_reg == DSI_DIV_W'(DSI_BLINK_CYCLES - 1));
        cnt_next   = tick ? '0 : cnt_reg + 1'b1;
        phase_next = tick ? ~phase_reg : phase_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_reg   <= '0;
            phase_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;

    // a tick never repeats within eight cycles of itself
    a_blink_period: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick |=> (!tick) [*8])
        else $error("blink tick came too soon");

    // the phase only moves on a tick, so the rate stays fixed
    a_phase_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !tick |=> $stable(phase))
        else $error("blink phase moved without a tick");

endmodule

// ---- rtl/dsi_status.sv ----
/*
 * dsi_status: sorts faults and environmental conditions into four severity
 * levels and shows the level on a status led and two open-drain wires.
 * Assumes fault inputs are synchronous to ref_clk; the external controller
 * provides pull-ups on both status wires.
 */
// Operation
// - exactly one of four severity levels
// - normal: green, wire1 low, wire2 high
// - warning: orange, wire1 toggles, wire2 high
// - serious: red flashing, wire1 high, wire2 toggles
// - critical: red steady, wire1 high, wire2 low
// - wires only grounded, reader supplies pull-up
// - harmful environment raises warning everywhere
// - damage during warning escalates to alarm
// - warning dismissable once environment acceptable
// - user thresholds per parameter plus preset
`timescale 1ns/1ps
module dsi_status
    import dsi_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire dsi_env_type env [DSI_NUM_PARAM],
    input  wire logic        impending_fault,
    input  wire logic        inoperable_fault,
    input  wire logic        dismiss,
    output dsi_level_type    level,
    output dsi_led_type      led_colour,
    output logic             led_on,
    output dsi_wire_type     wires,
    output logic             env_ok
);

    dsi_level_type        level_reg;
    dsi_level_type        level_next;
    logic                 warn_reg;
    logic                 warn_next;
    logic [DSI_NUM_PARAM-1:0] over;
    logic                 env_bad;
    logic                 tick;
    logic                 phase;
    dsi_led_type          colour_reg;
    dsi_led_type          colour_next;
    logic                 on_reg;
    logic                 on_next;
    dsi_wire_type         wires_reg;
    dsi_wire_type         wires_next;

    dsi_blink u_blink (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tick    (tick),
        .phase   (phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-parameter limit check: preset or enabled user limit
    genvar gi;
    generate
        for (gi = 0; gi < DSI_NUM_PARAM; gi++) begin : g_cmp
            assign over[gi] = (env[gi].value >= env[gi].harm_limit) ||
                (env[gi].user_en && env[gi].value >= env[gi].user_limit);
        end
    endgenerate

    assign env_bad = |over;
    assign env_ok  = ~env_bad;

    ////////////////////////////////////////////////////////////////////////
    // warning latch: set wins over dismiss; dismiss only when env is ok
    always_comb begin
        warn_next = warn_reg;
        if (env_bad) begin
            warn_next = 1'b1;
        end else if (dismiss) begin
            warn_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // severity: worst condition wins, alarms hold until reset
    always_comb begin
        level_next = DSI_NORMAL;
        if (inoperable_fault || level_reg == DSI_CRITICAL) begin
            level_next = DSI_CRITICAL;
        end else if (impending_fault || level_reg == DSI_SERIOUS) begin
            level_next = DSI_SERIOUS;
        end else if (warn_next) begin
            level_next = DSI_WARNING;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indication decode; 1 on a wire means released, pull-up gives the high
    always_comb begin
        colour_next       = DSI_LED_GREEN;
        on_next           = 1'b1;
        wires_next.s1_out = 1'b0;
        wires_next.s2_out = 1'b0;
        wires_next.s1_oe_n = 1'b0;
        wires_next.s2_oe_n = DSI_OE_RELEASE;
        unique case (level_reg)
            DSI_NORMAL: begin
                colour_next        = DSI_LED_GREEN;
                wires_next.s1_oe_n = 1'b0;
                wires_next.s2_oe_n = DSI_OE_RELEASE;
            end
            DSI_WARNING: begin
                colour_next        = DSI_LED_ORANGE;
                wires_next.s1_oe_n = phase;
                wires_next.s2_oe_n = DSI_OE_RELEASE;
            end
            DSI_SERIOUS: begin
                colour_next        = DSI_LED_RED;
                on_next            = phase;
                wires_next.s1_oe_n = DSI_OE_RELEASE;
                wires_next.s2_oe_n = phase;
            end
            DSI_CRITICAL: begin
                colour_next        = DSI_LED_RED;
                wires_next.s1_oe_n = DSI_OE_RELEASE;
                wires_next.s2_oe_n = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            level_reg  <= DSI_NORMAL;
            warn_reg   <= 1'b0;
            colour_reg <= DSI_LED_GREEN;
            on_reg     <= 1'b1;
            wires_reg  <= {1'b0, 1'b0, 1'b0, DSI_OE_RELEASE};
        end else begin
            level_reg  <= level_next;
            warn_reg   <= warn_next;
            colour_reg <= colour_next;
            on_reg     <= on_next;
            wires_reg  <= wires_next;
        end
    end

    assign level      = level_reg;
    assign led_colour = colour_reg;
    assign led_on     = on_reg;
    assign wires      = wires_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks; all in the ref_clk domain, quiet while reset is held
    default clocking chk_clk @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // two cycles in warning with a phase flip on the second
    sequence s_warn_flip;
        (level == DSI_WARNING) [*2] ##0 $changed(phase);
    endsequence

    // a warning met by dismiss while the environment is back in limits
    sequence s_warn_dismissed;
        level == DSI_WARNING && dismiss && env_ok
            && !impending_fault && !inoperable_fault;
    endsequence

    a_wire_never_high: assert property (
        !wires.s1_out && !wires.s2_out)
        else $error("status wire driven high");

    a_normal_show: assert property (
        level == DSI_NORMAL |=> led_colour == DSI_LED_GREEN && led_on
            && !wires.s1_oe_n && wires.s2_oe_n)
        else $error("normal indication wrong");

    a_warn_show: assert property (
        level == DSI_WARNING |=> led_colour == DSI_LED_ORANGE && led_on
            && wires.s2_oe_n)
        else $error("warning indication wrong");

    a_warn_toggle: assert property (
        s_warn_flip |=> $changed(wires.s1_oe_n))
        else $error("warning wire does not toggle");

    a_serious_show: assert property (
        level == DSI_SERIOUS |=> led_colour == DSI_LED_RED
            && wires.s1_oe_n && wires.s2_oe_n == $past(phase))
        else $error("serious indication wrong");

    // led flashes in step with the blink phase, one cycle late
    a_serious_flash: assert property (
        level == DSI_SERIOUS |=> led_on == $past(phase))
        else $error("serious led does not follow blink");

    a_critical_show: assert property (
        level == DSI_CRITICAL |=> led_colour == DSI_LED_RED && led_on
            && wires.s1_oe_n && !wires.s2_oe_n)
        else $error("critical indication wrong");

    a_env_warns: assert property (
        env_bad |=> level != DSI_NORMAL)
        else $error("harmful environment not warned");

    a_damage_escal: assert property (
        level == DSI_WARNING && inoperable_fault
            |=> level == DSI_CRITICAL)
        else $error("damage did not escalate");

    // the critical alarm stays up until reset; dismiss must not lower it
    a_alarm_sticky: assert property (
        level == DSI_CRITICAL |=> level == DSI_CRITICAL)
        else $error("critical alarm did not hold");

    a_dismiss_ok: assert property (
        s_warn_dismissed |=> level == DSI_NORMAL)
        else $error("warning not dismissed");

    a_user_limit: assert property (
        env[0].user_en && env[0].value >= env[0].user_limit |-> !env_ok)
        else $error("user limit ignored");

endmodule

// ---- verification/dsi_pullup_reader.sv ----
/*
 * dsi_pullup_reader: controller inputs with pull-ups on both status wires.
 * Assumes wires carries open-drain pairs, enable low meaning grounded.
 */
`timescale 1ns/1ps
module dsi_pullup_reader
    import dsi_pkg::*;
(
    input  wire dsi_wire_type wires,
    output logic              st1,
    output logic              st2
);
    // a released wire reads high only through our pull-up
    assign st1 = wires.s1_oe_n ? 1'b1 : wires.s1_out;
    assign st2 = wires.s2_oe_n ? 1'b1 : wires.s2_out;
endmodule

// ---- verification/tb_top.sv ----
/*
 * tb_top: self-checking bench for dsi_status with a pull-up reader.
 * Assumes 100 MHz ref_clk; blink period too long to see a toggle here.
 */
`timescale 1ns/1ps
module tb_top;
    import dsi_pkg::*;
    logic          ref_clk = 1'b0;
    logic          resetn = 1'b0;
    dsi_env_type   env [DSI_NUM_PARAM];
    logic          impending_fault = 1'b0;
    logic          inoperable_fault = 1'b0;
    logic          dismiss = 1'b0;
    dsi_level_type level;
    dsi_led_type   led_colour;
    logic          led_on;
    dsi_wire_type  wires;
    logic          env_ok;
    logic          st1;
    logic          st2;
    int            fail_count = 0;
    int            checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    dsi_status dut (.ref_clk(ref_clk), .resetn(resetn), .env(env),
        .impending_fault(impending_fault), .inoperable_fault(inoperable_fault),
        .dismiss(dismiss), .level(level), .led_colour(led_colour),
        .led_on(led_on), .wires(wires), .env_ok(env_ok));
    dsi_pullup_reader rdr (.wires(wires), .st1(st1), .st2(st2));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // {level, colour, led_on, st1, st2, any wire sourcing}
    function automatic logic [7:0] stat();
        return {level, led_colour, led_on, st1, st2,
                wires.s1_out | wires.s2_out};
    endfunction
    task automatic step(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        impending_fault = 1'b0;
        inoperable_fault = 1'b0;
        dismiss = 1'b0;
        foreach (env[i]) env[i] = '{12'h000, 12'hFFF, 12'hFFF, 1'b0};
        step(8);
        resetn = 1'b1;
        step(1);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios; warning masks st1 and serious masks led_on/st2 (blinking)
    task automatic t_reset();
        chk("normal", {DSI_NORMAL, DSI_LED_GREEN, 4'hA}, stat());
    endtask
    task automatic t_harm();
        env[1].value = 12'h800;
        env[1].harm_limit = 12'h800;
        dismiss = 1'b1;
        step(3);
        chk("env_ok", 8'h00, {7'h00, env_ok});
        chk("warn", {DSI_WARNING, DSI_LED_ORANGE, 4'hA},
            stat() & 8'hFB);
        env[1].value = 12'h7FF;
        dismiss = 1'b0;
        step(3);
        chk("latched", {DSI_WARNING, 6'h00}, stat() & 8'hC0);
        dismiss = 1'b1;
        step(1);
        dismiss = 1'b0;
        step(2);
        chk("dismissed", {DSI_NORMAL, DSI_LED_GREEN, 4'hA}, stat());
    endtask
    task automatic t_user();
        env[0].user_limit = 12'h100;
        env[0].value = 12'h100;
        step(1);
        chk("user off", 8'h01, {7'h00, env_ok});
        env[0].user_en = 1'b1;
        step(3);
        chk("user warn", {DSI_WARNING, DSI_LED_ORANGE, 4'hA},
            stat() & 8'hFB);
    endtask
    task automatic t_crit();
        inoperable_fault = 1'b1;
        step(3);
        chk("critical", {DSI_CRITICAL, DSI_LED_RED, 4'hC},
            stat());
        inoperable_fault = 1'b0;
        env[0].user_en = 1'b0;
        dismiss = 1'b1;
        step(3);
        dismiss = 1'b0;
        chk("sticky", {DSI_CRITICAL, DSI_LED_RED, 4'hC}, stat());
    endtask
    task automatic t_serious();
        do_reset();
        impending_fault = 1'b1;
        step(3);
        chk("serious", {DSI_SERIOUS, DSI_LED_RED, 4'h4},
            stat() & 8'hF5);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        do_reset();
        t_reset();
        t_harm();
        t_user();
        t_crit();
        t_serious();
        stop_test();
    end
    initial begin
        step(2000);
        fail_count++;
        stop_test();
    end
endmodule
